// ==== rrs_pkg.sv ====
// package: opcode patterns, field positions and constants for the return/rotate/sleep executor
package rrs_pkg;
    localparam int INSN_W   = 14;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int PC_W     = 13;
    localparam int WDT_W    = 8;
    localparam int PRE_W    = 8;
    localparam int DEST_BIT = 7;
    localparam int MSB      = 7;
    localparam logic [INSN_W-1:0] OP_RETURN = 14'h0008;
    localparam logic [INSN_W-1:0] OP_SLEEP  = 14'h0063;
    localparam logic [5:0]        OP_RRF_HI = 6'h0C;   // 00 1100
    localparam logic [5:0]        OP_RLF_HI = 6'h0D;   // 00 1101
    localparam logic [WDT_W-1:0]  WDT_CLEAR = 8'h00;
    localparam logic [PRE_W-1:0]  PRE_CLEAR = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [PC_W-1:0]   PC_ZERO   = 13'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

    typedef enum logic [1:0] {OPK_NONE, OPK_RET, OPK_RRF, OPK_RLF} op_kind_t;

    // decoded instruction fields
    typedef struct packed {
        logic [ADDR_W-1:0] faddr;
        logic              dest_f;
    } operand_t;

    // register-file write request
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;
endpackage

// ==== return_rotate_sleep_ops.sv ====
// executor for subroutine return, rotate through carry and sleep entry
// What this block does
// - return pops stack into pc, flags kept
// - return takes two cycles, next fetch flushed
// - rotate right: carry into bit7, bit0 out
// - rotate left decoded from 00 1101 d fffffff
// - rotate left: carry into bit0, bit7 out
// - dest 0 writes accumulator, file unchanged
// - rotate right dest 1 writes file register
// - rotate left dest 1 writes file register
// - sleep clears power-down flag
// - sleep sets time-out flag
// - sleep clears watchdog counter and prescaler
// - sleep halts oscillator and execution
module return_rotate_sleep_ops (
    input  wire logic                              core_clk,      // core clock, 25 MHz
    input  wire logic                              arst_n,        // async reset, active low
    input  wire logic                              insn_valid,    // instruction present this cycle
    input  wire logic [rrs_pkg::INSN_W-1:0]        insn,          // instruction word
    input  wire logic [rrs_pkg::DATA_W-1:0]        file_rdata,    // addressed file register contents
    input  wire logic                              carry_in,      // current carry flag
    input  wire logic [rrs_pkg::PC_W-1:0]          stack_top_value, // top of hardware stack
    input  wire logic                              wdt_tick,      // watchdog prescaler input tick
    output logic [rrs_pkg::ADDR_W-1:0]             file_raddr,    // file register read address
    output rrs_pkg::file_wr_t                      file_wr,       // file register write
    output logic                                   acc_we,        // accumulator write strobe
    output logic [rrs_pkg::DATA_W-1:0]             acc_wdata,     // accumulator write data
    output logic                                   carry_we,      // carry write strobe
    output logic                                   carry_out,     // new carry value
    output logic                                   stack_pop,     // pop the hardware stack
    output logic                                   pc_load,       // load pc with pc_value
    output logic [rrs_pkg::PC_W-1:0]               pc_value,      // value for pc
    output logic                                   fetch_flush,   // discard current fetch
    output logic                                   timeout_status_flag,   // time-out flag, active low sense
    output logic                                   powerdown_status_flag, // power-down flag, active low sense
    output logic [rrs_pkg::WDT_W-1:0]              watchdog_counter, // watchdog count
    output logic                                   osc_run,       // main oscillator enable
    output logic                                   sleeping       // core is asleep
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic rrs_pkg::op_kind_t decode(input logic [rrs_pkg::INSN_W-1:0] w);
        rrs_pkg::op_kind_t k;
        k = rrs_pkg::OPK_NONE;
        if (w == rrs_pkg::OP_RETURN) begin
            k = rrs_pkg::OPK_RET;
        // the rotate pair differs only in bit 8; the top field width follows the constant
        end else if (w[rrs_pkg::INSN_W-1 -: $bits(rrs_pkg::OP_RRF_HI)] == rrs_pkg::OP_RRF_HI) begin
            k = rrs_pkg::OPK_RRF;
        end else if (w[rrs_pkg::INSN_W-1 -: $bits(rrs_pkg::OP_RLF_HI)] == rrs_pkg::OP_RLF_HI) begin
            k = rrs_pkg::OPK_RLF;
        end
        return k;
    endfunction

    rrs_pkg::op_kind_t kind;
    rrs_pkg::operand_t opnd;
    logic              is_sleep;
    logic              go;
    logic              flush_r;
    logic              sleep_r;
    logic              tick_s1;
    logic              tick_s2;
    logic              tick_s3;
    logic [rrs_pkg::PRE_W-1:0] presc_r;

    // execution stalls while asleep; the cycle after a return is the discarded fetch
    assign go       = insn_valid && !sleep_r && !flush_r;
    assign kind     = go ? decode(insn) : rrs_pkg::OPK_NONE;
    assign is_sleep = go && (insn == rrs_pkg::OP_SLEEP);
    assign opnd     = '{faddr: insn[rrs_pkg::ADDR_W-1:0], dest_f: insn[rrs_pkg::DEST_BIT]};

    // read address follows the instruction combinationally so data is back this cycle
    assign file_raddr = opnd.faddr;

    // ----------------------------------------
    // rotate datapath
    // ----------------------------------------
    logic [rrs_pkg::DATA_W-1:0] rot_res;
    logic                       rot_c;
    always_comb begin
        rot_res = file_rdata;
        rot_c   = carry_in;
        if (kind == rrs_pkg::OPK_RRF) begin
            rot_res = {carry_in, file_rdata[rrs_pkg::MSB:1]};
            rot_c   = file_rdata[0];
        end else if (kind == rrs_pkg::OPK_RLF) begin
            rot_res = {file_rdata[rrs_pkg::MSB-1:0], carry_in};
            rot_c   = file_rdata[rrs_pkg::MSB];
        end
    end

    logic is_rot;
    assign is_rot = (kind == rrs_pkg::OPK_RRF) || (kind == rrs_pkg::OPK_RLF);

    // results register out in one cycle, so a rotate never stalls the pipe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            file_wr   <= '{we: 1'b0, addr: rrs_pkg::ADDR_ZERO, data: rrs_pkg::DATA_ZERO};
            acc_we    <= 1'b0;
            acc_wdata <= rrs_pkg::DATA_ZERO;
            carry_we  <= 1'b0;
            carry_out <= 1'b0;
        end else begin
            file_wr.we   <= is_rot && opnd.dest_f;
            file_wr.addr <= opnd.faddr;
            file_wr.data <= rot_res;
            acc_we       <= is_rot && !opnd.dest_f;
            acc_wdata    <= rot_res;
            carry_we     <= is_rot;
            carry_out    <= rot_c;
        end
    end

    // ----------------------------------------
    // return: pop and branch, flush one fetch
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_pop   <= 1'b0;
            pc_load     <= 1'b0;
            pc_value    <= rrs_pkg::PC_ZERO;
            fetch_flush <= 1'b0;
            flush_r     <= 1'b0;
        end else begin
            stack_pop   <= kind == rrs_pkg::OPK_RET;
            pc_load     <= kind == rrs_pkg::OPK_RET;
            pc_value    <= stack_top_value;
            fetch_flush <= kind == rrs_pkg::OPK_RET;
            flush_r     <= kind == rrs_pkg::OPK_RET;
        end
    end

    // ----------------------------------------
    // sleep and watchdog
    // ----------------------------------------
    // tick from the watchdog oscillator domain: three flops, change seen when 2nd and 3rd agree
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
        end else begin
            tick_s1 <= wdt_tick;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
        end
    end

    // a level is accepted only once the 2nd and 3rd flops agree; a rise counts once
    logic tick_lvl_r;
    logic tick_rise;
    assign tick_rise = (tick_s2 == tick_s3) && tick_s3 && !tick_lvl_r;

    // accepted tick level; resets to the pin's idle low so no false rise follows reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_lvl_r <= 1'b0;
        end else if (tick_s2 == tick_s3) begin
            tick_lvl_r <= tick_s3;
        end
    end

    // prescaler wraps into the watchdog count; sleep clears both
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_r          <= rrs_pkg::PRE_CLEAR;
            watchdog_counter <= rrs_pkg::WDT_CLEAR;
        end else if (is_sleep) begin
            presc_r          <= rrs_pkg::PRE_CLEAR;
            watchdog_counter <= rrs_pkg::WDT_CLEAR;
        end else if (tick_rise) begin
            presc_r <= presc_r + 1'b1;
            if (&presc_r) begin
                watchdog_counter <= watchdog_counter + 1'b1;
            end
        end
    end

    // flags reset high (no event seen); wake-up lies outside this block, so sleep holds
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_status_flag   <= 1'b1;
            powerdown_status_flag <= 1'b1;
            sleep_r               <= 1'b0;
            sleeping              <= 1'b0;
            osc_run               <= 1'b1;
        end else if (is_sleep) begin
            timeout_status_flag   <= 1'b1;
            powerdown_status_flag <= 1'b0;
            sleep_r               <= 1'b1;
            sleeping              <= 1'b1;
            osc_run               <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_ret_pops_pc: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RET) |=> (stack_pop && pc_load && pc_value == $past(stack_top_value) && !carry_we))
        else $error("return did not pop stack into pc");
    chk_ret_flush_next: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RET) |=> (kind == rrs_pkg::OPK_NONE) ##1 !fetch_flush)
        else $error("return did not discard exactly one fetch");
    chk_rrf_result: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RRF) |=> (carry_out == $past(file_rdata[0])
            && (acc_we ? acc_wdata : file_wr.data) == {$past(carry_in), $past(file_rdata[rrs_pkg::MSB:1])}))
        else $error("rotate right result wrong");
    chk_rlf_decode: assert property (@(posedge core_clk) disable iff (!arst_n)
        (go && insn[rrs_pkg::INSN_W-1 -: $bits(rrs_pkg::OP_RLF_HI)] == rrs_pkg::OP_RLF_HI) |-> kind == rrs_pkg::OPK_RLF)
        else $error("rotate left not decoded");
    chk_rlf_result: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RLF) |=> (carry_we && carry_out == $past(file_rdata[rrs_pkg::MSB])
            && (acc_we ? acc_wdata : file_wr.data) == {$past(file_rdata[rrs_pkg::MSB-1:0]), $past(carry_in)}))
        else $error("rotate left result wrong");
    chk_dest_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
        (is_rot && !opnd.dest_f) |=> (acc_we && !file_wr.we))
        else $error("dest 0 did not go to accumulator only");
    chk_rrf_dest_file: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RRF && opnd.dest_f) |=> (file_wr.we && !acc_we && file_wr.addr == $past(opnd.faddr)))
        else $error("rotate right dest 1 did not write file");
    chk_rlf_dest_file: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RLF && opnd.dest_f) |=> (file_wr.we && !acc_we))
        else $error("rotate left dest 1 did not write file");
    chk_sleep_pd: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_sleep |=> !powerdown_status_flag)
        else $error("power-down flag not cleared by sleep");
    chk_sleep_to: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_sleep |=> timeout_status_flag)
        else $error("time-out flag not set by sleep");
    chk_sleep_wdt: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_sleep |=> (watchdog_counter == rrs_pkg::WDT_CLEAR && presc_r == rrs_pkg::PRE_CLEAR))
        else $error("watchdog not cleared by sleep");
    chk_sleep_halt: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_sleep |=> (!osc_run && sleeping) ##1 (kind == rrs_pkg::OPK_NONE && !osc_run))
        else $error("sleep did not halt core");
    chk_sleep_decode: assert property (@(posedge core_clk) disable iff (!arst_n)
        (go && insn == rrs_pkg::OP_SLEEP) |-> is_sleep)
        else $error("sleep opcode not recognised");
    chk_rot_one_cycle: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_rot |=> (carry_we && (acc_we || file_wr.we)))
        else $error("rotate did not complete in one cycle");

    // ----------------------------------------
    // gating and side-effect checks
    // ----------------------------------------
    // the fetch behind a return must never execute
    chk_flush_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        flush_r |-> (kind == rrs_pkg::OPK_NONE && !is_sleep))
        else $error("flushed fetch was executed");

    // nothing executes once asleep; only reset leaves sleep here
    chk_asleep_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        sleep_r |-> (kind == rrs_pkg::OPK_NONE && !is_sleep))
        else $error("instruction executed while asleep");

    // the oscillator stays stopped for the whole sleep
    chk_osc_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        sleep_r |-> (!osc_run && sleeping))
        else $error("oscillator running while asleep");

    // a return touches no data register and no flag
    chk_ret_no_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RET) |=> (!acc_we && !file_wr.we && !carry_we))
        else $error("return wrote data or carry");

    // a rotate never branches, so nothing is flushed behind it
    chk_rot_no_branch: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_rot |=> (!stack_pop && !pc_load && !fetch_flush))
        else $error("rotate disturbed the program counter");

    // one pop per return, never two in a row
    chk_pop_single: assert property (@(posedge core_clk) disable iff (!arst_n)
        stack_pop |=> !stack_pop)
        else $error("stack popped twice");

    // exactly one fetch is discarded
    chk_flush_single: assert property (@(posedge core_clk) disable iff (!arst_n)
        fetch_flush |=> !fetch_flush)
        else $error("more than one fetch discarded");

    // the watchdog count moves only on a tick or a sleep
    chk_wdt_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!is_sleep && !tick_rise) |=> $stable(watchdog_counter))
        else $error("watchdog moved without a tick");

    // the prescaler moves only on a tick or a sleep
    chk_presc_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!is_sleep && !tick_rise) |=> $stable(presc_r))
        else $error("prescaler moved without a tick");

    // power-down flag stays clear through sleep
    chk_pd_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        sleep_r |-> !powerdown_status_flag)
        else $error("power-down flag set while asleep");

    // time-out flag stays set through sleep
    chk_to_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        sleep_r |-> timeout_status_flag)
        else $error("time-out flag clear while asleep");

    // opcodes outside this block leave every strobe low
    chk_idle_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_NONE) |=> (!acc_we && !file_wr.we && !carry_we && !stack_pop))
        else $error("strobe raised with nothing decoded");

    // rotate right always updates carry
    chk_rrf_carry_we: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RRF) |=> carry_we)
        else $error("rotate right left carry alone");

    // rotate left always updates carry
    chk_rlf_carry_we: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RLF) |=> carry_we)
        else $error("rotate left left carry alone");

    // rotate left write-back goes to the addressed register
    chk_rlf_file_addr: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RLF && opnd.dest_f) |=> (file_wr.addr == $past(opnd.faddr)))
        else $error("rotate left wrote the wrong register");

    // rotate right with dest 0 leaves the file alone
    chk_rrf_dest_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RRF && !opnd.dest_f) |=> (acc_we && !file_wr.we))
        else $error("rotate right dest 0 wrote file");

    // rotate left with dest 0 leaves the file alone
    chk_rlf_dest_acc: assert property (@(posedge core_clk) disable iff (!arst_n)
        (kind == rrs_pkg::OPK_RLF && !opnd.dest_f) |=> (acc_we && !file_wr.we))
        else $error("rotate left dest 0 wrote file");

    // sleep is taken once; later sleep words are ignored
    chk_sleep_once: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_sleep |=> !is_sleep)
        else $error("sleep taken twice");

endmodule

// ==== tb.sv ====
// testbench: drives the return, rotate and sleep executor and checks its ports
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic                          core_clk, arst_n, insn_valid, carry_in, wdt_tick;
    logic [rrs_pkg::INSN_W-1:0]    insn;
    logic [rrs_pkg::DATA_W-1:0]    file_rdata, acc_wdata;
    logic [rrs_pkg::PC_W-1:0]      stack_top_value, pc_value;
    logic [rrs_pkg::ADDR_W-1:0]    file_raddr;
    rrs_pkg::file_wr_t             file_wr;
    logic                          acc_we, carry_we, carry_out, stack_pop, pc_load, fetch_flush;
    logic                          timeout_status_flag, powerdown_status_flag, osc_run, sleeping;
    logic [rrs_pkg::WDT_W-1:0]     watchdog_counter;
    int                            error_cnt = 0;
    int                            n_checks  = 0;

    return_rotate_sleep_ops dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .insn_valid(insn_valid), .insn(insn),
        .file_rdata(file_rdata), .carry_in(carry_in), .stack_top_value(stack_top_value),
        .wdt_tick(wdt_tick), .file_raddr(file_raddr), .file_wr(file_wr), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .carry_we(carry_we), .carry_out(carry_out), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .fetch_flush(fetch_flush),
        .timeout_status_flag(timeout_status_flag), .powerdown_status_flag(powerdown_status_flag),
        .watchdog_counter(watchdog_counter), .osc_run(osc_run), .sleeping(sleeping)
    );

    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // compare one value, count it, report at once on a difference
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one instruction slot: drive just after the edge, the next slot's edge takes it;
    // on return the outputs belong to the slot before this one
    task automatic slot(input logic v, input logic [13:0] i, input logic [7:0] r, input logic c);
        @(posedge core_clk);
        insn_valid <= v;
        insn       <= i;
        file_rdata <= r;
        carry_in   <= c;
        #1;
    endtask

    // expected results of a rotate (or of nothing, when all strobes are 0)
    task automatic rot_chk(input logic awe, input logic [7:0] acc, input logic fwe,
                           input logic [6:0] fa, input logic [7:0] fd, input logic cwe, input logic cy);
        chk("acc_we", acc_we, awe);
        chk("file_we", file_wr.we, fwe);
        chk("carry_we", carry_we, cwe);
        if (awe) chk("acc_wdata", acc_wdata, acc);
        if (fwe) chk("file_addr", file_wr.addr, fa);
        if (fwe) chk("file_data", file_wr.data, fd);
        if (cwe) chk("carry_out", carry_out, cy);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // hang guard: the sequence needs well under 3000 cycles
    initial begin
        #(5000 * 40);
        error_cnt++;
        end_of_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0; insn_valid = 1'b0; insn = 14'h0000; file_rdata = 8'h00;
        carry_in = 1'b0; wdt_tick = 1'b0; stack_top_value = 13'h1ABC;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        chk("osc_run", osc_run, 1'b1);
        chk("sleeping", sleeping, 1'b0);
        chk("pd_flag", powerdown_status_flag, 1'b1);
        chk("to_flag", timeout_status_flag, 1'b1);
        // back-to-back rotates, each result one slot later
        slot(1'b1, 14'h0C12, 8'hE6, 1'b0);
        chk("file_raddr", file_raddr, 7'h12);
        slot(1'b1, 14'h0CFF, 8'h01, 1'b1);
        rot_chk(1'b1, 8'h73, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0);
        slot(1'b1, 14'h0D20, 8'hE6, 1'b0);
        rot_chk(1'b0, 8'h00, 1'b1, 7'h7F, 8'h80, 1'b1, 1'b1);
        slot(1'b1, 14'h0D85, 8'h80, 1'b1);
        chk("file_raddr", file_raddr, 7'h05);
        rot_chk(1'b1, 8'hCC, 1'b0, 7'h00, 8'h00, 1'b1, 1'b1);
        slot(1'b1, 14'h0E85, 8'h5A, 1'b1);
        rot_chk(1'b0, 8'h00, 1'b1, 7'h05, 8'h01, 1'b1, 1'b1);
        // a neighbouring opcode outside the rotate pair writes nothing
        slot(1'b1, 14'h0008, 8'h00, 1'b0);
        rot_chk(1'b0, 8'h00, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0);
        // return, with a rotate in the flushed slot behind it
        slot(1'b1, 14'h0CFF, 8'h01, 1'b1);
        chk("stack_pop", stack_pop, 1'b1);
        chk("pc_load", pc_load, 1'b1);
        chk("pc_value", pc_value, 13'h1ABC);
        chk("fetch_flush", fetch_flush, 1'b1);
        rot_chk(1'b0, 8'h00, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0);
        slot(1'b0, 14'h0000, 8'h00, 1'b0);
        rot_chk(1'b0, 8'h00, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0);
        chk("stack_pop", stack_pop, 1'b0);
        chk("pc_load", pc_load, 1'b0);
        // 600 tick rises: the 8-bit prescaler carries twice into the counter;
        // each level holds two cycles so the 2nd and 3rd sync flops can agree
        repeat (1200) begin
            repeat (2) @(posedge core_clk);
            wdt_tick <= ~wdt_tick;
        end
        repeat (6) @(posedge core_clk);
        #1;
        chk("watchdog", watchdog_counter, 8'h02);
        // one code below sleep must not put the core to sleep
        slot(1'b1, 14'h0062, 8'h00, 1'b0);
        slot(1'b1, 14'h0063, 8'h00, 1'b0);
        chk("sleeping", sleeping, 1'b0);
        slot(1'b1, 14'h0CFF, 8'h01, 1'b1);
        chk("pd_flag", powerdown_status_flag, 1'b0);
        chk("to_flag", timeout_status_flag, 1'b1);
        chk("watchdog", watchdog_counter, 8'h00);
        chk("osc_run", osc_run, 1'b0);
        chk("sleeping", sleeping, 1'b1);
        slot(1'b0, 14'h0000, 8'h00, 1'b0);
        rot_chk(1'b0, 8'h00, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0);
        end_of_test;
    end
endmodule
